// file: include/usart_consts.svh
`ifndef USART_CONSTS_SVH
`define USART_CONSTS_SVH

// register indices on the plain register port
`define ADDR_DATA        3'h0
`define ADDR_CTRL_A      3'h1
`define ADDR_CTRL_B      3'h2
`define ADDR_CTRL_C      3'h3
`define ADDR_DIV_LOW     3'h4
`define ADDR_DIV_HIGH    3'h5

// ctrl_status_a bit positions
`define A_RX_COMPLETE    7
`define A_TX_COMPLETE    6
`define A_TX_EMPTY       5
`define A_FRAMING_ERR    4
`define A_OVERRUN        3
`define A_PARITY_ERR     2
`define A_DOUBLE_SPEED   1

// ctrl_status_b bit positions
`define B_IE_RX_DONE     7
`define B_IE_TX_DONE     6
`define B_IE_TX_EMPTY    5
`define B_RX_EN          4
`define B_TX_EN          3
`define B_SIZE_HI        2
`define B_RX_NINTH       1
`define B_TX_NINTH       0

// ctrl_status_c bit positions
`define C_XFER_DIR       7
`define C_SYNC_MODE      6
`define C_PARITY_HI      5
`define C_PARITY_LO      4
`define C_STOP_BITS      3
`define C_SIZE_HI        2
`define C_SIZE_LO        1
`define C_POLARITY       0

// reset values
`define RST_SIZE         3'h3
`define RST_DIV          12'h000

// timing counts in baud generator ticks, then the nine-bit size code and data bit counts
`define LAST_TICK_NORMAL 4'hf
`define LAST_TICK_DOUBLE 4'h7
`define MID_TICK_NORMAL  4'h7
`define MID_TICK_DOUBLE  4'h3
`define SIZE_NINE_CODE   3'h7
`define BITS_NINE        4'h9
`define BITS_MIN         4'h5

`endif

// file: include/usart_pkg.sv
package usart_pkg;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP1, TX_STOP2} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;

  typedef struct packed {
    logic out;
    logic oe;
  } xck_pin_t;

  typedef struct packed {
    logic rx_done;
    logic tx_empty;
    logic tx_done;
  } irq_t;

  typedef struct packed {
    logic       framing_error;
    logic       parity_err;
    logic [8:0] data;
  } rx_entry_t;

  typedef struct packed {
    logic [11:0] baud_cnt;
    logic [7:0]  div_low;
    logic [3:0]  div_high;
    logic        double_speed;
    logic        tx_done;
    logic        overrun;
    logic [2:0]  ie;
    logic        rx_en;
    logic        tx_en;
    logic [2:0]  char_size;
    logic        tx_ninth_bit;
    logic        sync_clock_polarity;
    logic        stop_bits_select;
    logic [1:0]  parity_mode;
    logic        sync_mode_select;
    logic        xfer_clock_dir;
    logic        xck_s1;
    logic        xck_s2;
    logic        xck_prev;
    logic        rx_s1;
    logic        rx_s2;
    logic [3:0]  tx_div;
    tx_state_t   tx_st;
    logic [8:0]  tx_shift;
    logic [3:0]  tx_bit;
    logic        tx_par;
    logic [8:0]  tx_buf;
    logic        tx_full;
    logic [3:0]  rx_cnt;
    rx_state_t   rx_st;
    logic [8:0]  rx_shift;
    logic [3:0]  rx_bit;
    logic        rx_par;
    logic        rx_perr;
    rx_entry_t   q0;
    rx_entry_t   q1;
    logic [1:0]  q_count;
    logic        serial_out;
    xck_pin_t    xck;
    irq_t        irq;
    logic [7:0]  rd_data;
  } state_t;

endpackage : usart_pkg

// file: logic/usart_core.sv
`timescale 1ns/1ns
`default_nettype none
`include "usart_consts.svh"

// Function
// - four clock modes; sync_mode_select picks asynchronous or synchronous
// - in sync mode xfer_clock_dir chooses master (output) or slave (input)
// - transfer clock pin is only driven or used in synchronous mode
// - baud down-counter reloads at zero and on a divisor low byte write
// - baud generator pulses once per zero, rate clk over divisor plus one
// - transmitter divides baud pulses by 16, 8, or 2 by mode
// - divisor is 12 bits from high and low register bytes
// - double speed affects only asynchronous mode, 16 becomes 8
// - slave clock passes a sync register and an edge detector
// - sync input sampled on the edge opposite the output change edge
// - polarity 0: change on rising, sample on falling; 1 reversed
// - frame: start, 5 to 9 data bits, parity none/even/odd, 1 or 2 stops
// - order: start, data lsb first, parity, stop bits
// - after a frame, start the next at once or idle high
// - transmitter and receiver share size and parity settings; stop setting is transmit only
// - receiver checks only the first stop bit for framing errors
// - parity is xor of data bits, inverted for odd
// - single transmit buffer ahead of the shift register, no gap
// - two-level receive buffer with framing, overrun and parity errors
// - three interrupt sources: tx complete, tx buffer empty, rx complete
// - tx_buffer_empty set while buffer empty, clear while it holds data
module usart_core #(
  parameter int BAUD_W = 12
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire usart_pkg::bus_req_t req,
  output var  logic [7:0]        rd_data,
  input  wire logic              serial_in,
  output var  logic              serial_out,
  input  wire logic              xck_in,
  output var  usart_pkg::xck_pin_t xck,
  output var  usart_pkg::irq_t   irq
);

  if (BAUD_W != 12) begin : g_baud_w_check
    $error("usart_core serves a 12-bit divisor only");
  end

  usart_pkg::state_t st_ff;
  usart_pkg::state_t nxt_st;

  function automatic logic parity_of(input logic [8:0] d, input logic [3:0] nbits,
                                     input logic odd);
    logic x;
    x = odd;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < nbits) x = x ^ d[i];
    end
    return x;
  endfunction : parity_of

  logic       sync_m;
  logic       master;
  logic       slave;
  logic       baud_tick;
  logic [3:0] nbits;
  logic [3:0] last_tick;
  logic [3:0] mid_tick;
  logic       edge_rise;
  logic       edge_fall;
  logic       change_edge;
  logic       sample_edge;
  logic       tx_tick;
  logic       rx_line;
  logic       rx_sample;
  logic [8:0] tx_data_mask;
  logic [2:0] cnt_after_pop;
  usart_pkg::rx_entry_t new_entry;
  logic       push;
  logic       pop;

  always_comb begin
    nxt_st = st_ff;
    sync_m = st_ff.sync_mode_select;
    master = sync_m && st_ff.xfer_clock_dir;
    slave  = sync_m && !st_ff.xfer_clock_dir;
    baud_tick = (st_ff.baud_cnt == 12'h000);
    nbits = (st_ff.char_size == `SIZE_NINE_CODE) ? `BITS_NINE
          : ({2'b00, st_ff.char_size[1:0]} + `BITS_MIN);
    last_tick = st_ff.double_speed ? `LAST_TICK_DOUBLE : `LAST_TICK_NORMAL;
    mid_tick  = st_ff.double_speed ? `MID_TICK_DOUBLE : `MID_TICK_NORMAL;
    tx_data_mask = 9'h000;
    new_entry = '0;
    push = 1'b0;
    pop = 1'b0;
    cnt_after_pop = 3'h0;

    // baud generator
    if (req.wr && req.addr == `ADDR_DIV_LOW) begin
      nxt_st.baud_cnt = {st_ff.div_high, req.wdata};
    end else if (baud_tick) begin
      nxt_st.baud_cnt = {st_ff.div_high, st_ff.div_low};
    end else begin
      nxt_st.baud_cnt = st_ff.baud_cnt - 12'h001;
    end

    // slave clock: first flop feeds only the second
    nxt_st.xck_s1   = xck_in;
    nxt_st.xck_s2   = st_ff.xck_s1;
    nxt_st.xck_prev = st_ff.xck_s2;
    nxt_st.rx_s1    = serial_in;
    nxt_st.rx_s2    = st_ff.rx_s1;
    rx_line = st_ff.rx_s2;

    // master clock toggles each baud pulse, giving the divide by 2
    if (master) begin
      if (baud_tick) nxt_st.xck.out = !st_ff.xck.out;
    end else begin
      nxt_st.xck.out = st_ff.sync_clock_polarity;
    end
    nxt_st.xck.oe = master;

    if (master) begin
      edge_rise = baud_tick && !st_ff.xck.out;
      edge_fall = baud_tick && st_ff.xck.out;
    end else begin
      edge_rise = slave && st_ff.xck_s2 && !st_ff.xck_prev;
      edge_fall = slave && !st_ff.xck_s2 && st_ff.xck_prev;
    end
    change_edge = st_ff.sync_clock_polarity ? edge_fall : edge_rise;
    sample_edge = st_ff.sync_clock_polarity ? edge_rise : edge_fall;

    // transmitter bit clock
    tx_tick = 1'b0;
    if (sync_m) begin
      tx_tick = change_edge;
      nxt_st.tx_div = 4'h0;
    end else if (baud_tick) begin
      if (st_ff.tx_div >= last_tick) begin
        nxt_st.tx_div = 4'h0;
        tx_tick = 1'b1;
      end else begin
        nxt_st.tx_div = st_ff.tx_div + 4'h1;
      end
    end

    for (int i = 0; i < 9; i++) begin
      tx_data_mask[i] = (4'(i) < nbits);
    end

    if (tx_tick) begin
      unique case (st_ff.tx_st)
        usart_pkg::TX_IDLE: begin
          nxt_st.serial_out = 1'b1;
          if (st_ff.tx_full && st_ff.tx_en) begin
            nxt_st.tx_shift = st_ff.tx_buf & tx_data_mask;
            nxt_st.tx_par = parity_of(st_ff.tx_buf, nbits, st_ff.parity_mode[0]);
            nxt_st.tx_full = 1'b0;
            nxt_st.serial_out = 1'b0;
            nxt_st.tx_st = usart_pkg::TX_START;
          end
        end
        usart_pkg::TX_START: begin
          nxt_st.serial_out = st_ff.tx_shift[0];
          nxt_st.tx_shift = {1'b0, st_ff.tx_shift[8:1]};
          nxt_st.tx_bit = 4'h1;
          nxt_st.tx_st = usart_pkg::TX_DATA;
        end
        usart_pkg::TX_DATA: begin
          if (st_ff.tx_bit == nbits) begin
            if (st_ff.parity_mode[1]) begin
              nxt_st.serial_out = st_ff.tx_par;
              nxt_st.tx_st = usart_pkg::TX_PARITY;
            end else begin
              nxt_st.serial_out = 1'b1;
              nxt_st.tx_st = usart_pkg::TX_STOP1;
            end
          end else begin
            nxt_st.serial_out = st_ff.tx_shift[0];
            nxt_st.tx_shift = {1'b0, st_ff.tx_shift[8:1]};
            nxt_st.tx_bit = st_ff.tx_bit + 4'h1;
          end
        end
        usart_pkg::TX_PARITY: begin
          nxt_st.serial_out = 1'b1;
          nxt_st.tx_st = usart_pkg::TX_STOP1;
        end
        usart_pkg::TX_STOP1, usart_pkg::TX_STOP2: begin
          if (st_ff.tx_st == usart_pkg::TX_STOP1 && st_ff.stop_bits_select) begin
            nxt_st.serial_out = 1'b1;
            nxt_st.tx_st = usart_pkg::TX_STOP2;
          end else if (st_ff.tx_full && st_ff.tx_en) begin
            // back to back: next start bit follows the last stop at once
            nxt_st.tx_shift = st_ff.tx_buf & tx_data_mask;
            nxt_st.tx_par = parity_of(st_ff.tx_buf, nbits, st_ff.parity_mode[0]);
            nxt_st.tx_full = 1'b0;
            nxt_st.serial_out = 1'b0;
            nxt_st.tx_st = usart_pkg::TX_START;
          end else begin
            nxt_st.serial_out = 1'b1;
            nxt_st.tx_st = usart_pkg::TX_IDLE;
            nxt_st.tx_done = 1'b1;
          end
        end
      endcase
    end

    // receiver
    rx_sample = 1'b0;
    if (sync_m) begin
      rx_sample = sample_edge;
      nxt_st.rx_cnt = 4'h0;
    end else if (baud_tick && st_ff.rx_st != usart_pkg::RX_IDLE) begin
      if (st_ff.rx_st == usart_pkg::RX_START) begin
        nxt_st.rx_cnt = st_ff.rx_cnt + 4'h1;
      end else if (st_ff.rx_cnt >= last_tick) begin
        nxt_st.rx_cnt = 4'h0;
        rx_sample = 1'b1;
      end else begin
        nxt_st.rx_cnt = st_ff.rx_cnt + 4'h1;
      end
    end

    unique case (st_ff.rx_st)
      usart_pkg::RX_IDLE: begin
        nxt_st.rx_bit = 4'h0;
        nxt_st.rx_par = 1'b0;
        nxt_st.rx_perr = 1'b0;
        nxt_st.rx_shift = 9'h000;
        if (st_ff.rx_en && !rx_line) begin
          if (sync_m && sample_edge) begin
            nxt_st.rx_st = usart_pkg::RX_DATA;
          end else if (!sync_m && baud_tick) begin
            nxt_st.rx_cnt = 4'h0;
            nxt_st.rx_st = usart_pkg::RX_START;
          end
        end
      end
      usart_pkg::RX_START: begin
        // a low glitch shorter than half a bit is dropped here
        if (sync_m) begin
          nxt_st.rx_st = usart_pkg::RX_IDLE;
        end else if (baud_tick && st_ff.rx_cnt == mid_tick) begin
          nxt_st.rx_cnt = 4'h0;
          nxt_st.rx_st = rx_line ? usart_pkg::RX_IDLE : usart_pkg::RX_DATA;
        end
      end
      usart_pkg::RX_DATA: begin
        if (rx_sample) begin
          nxt_st.rx_shift[st_ff.rx_bit] = rx_line;
          nxt_st.rx_par = st_ff.rx_par ^ rx_line;
          nxt_st.rx_bit = st_ff.rx_bit + 4'h1;
          if (st_ff.rx_bit + 4'h1 == nbits) begin
            nxt_st.rx_st = st_ff.parity_mode[1] ? usart_pkg::RX_PARITY : usart_pkg::RX_STOP;
          end
        end
      end
      usart_pkg::RX_PARITY: begin
        if (rx_sample) begin
          nxt_st.rx_perr = rx_line ^ st_ff.rx_par ^ st_ff.parity_mode[0];
          nxt_st.rx_st = usart_pkg::RX_STOP;
        end
      end
      usart_pkg::RX_STOP: begin
        // second stop bit is never looked at
        if (rx_sample) begin
          new_entry.framing_error = !rx_line;
          new_entry.parity_err = st_ff.rx_perr;
          new_entry.data = st_ff.rx_shift;
          push = 1'b1;
          nxt_st.rx_st = usart_pkg::RX_IDLE;
        end
      end
      default: nxt_st.rx_st = usart_pkg::RX_IDLE;
    endcase
    if (!st_ff.rx_en) nxt_st.rx_st = usart_pkg::RX_IDLE;

    // register writes
    if (req.wr) begin
      unique case (req.addr)
        `ADDR_DATA: begin
          nxt_st.tx_buf = {st_ff.tx_ninth_bit, req.wdata};
          nxt_st.tx_full = 1'b1;
        end
        `ADDR_CTRL_A: begin
          nxt_st.double_speed = req.wdata[`A_DOUBLE_SPEED];
          if (req.wdata[`A_TX_COMPLETE]) nxt_st.tx_done = 1'b0;
        end
        `ADDR_CTRL_B: begin
          nxt_st.ie = {req.wdata[`B_IE_RX_DONE], req.wdata[`B_IE_TX_EMPTY],
                       req.wdata[`B_IE_TX_DONE]};
          nxt_st.rx_en = req.wdata[`B_RX_EN];
          nxt_st.tx_en = req.wdata[`B_TX_EN];
          nxt_st.char_size[2] = req.wdata[`B_SIZE_HI];
          nxt_st.tx_ninth_bit = req.wdata[`B_TX_NINTH];
        end
        `ADDR_CTRL_C: begin
          nxt_st.xfer_clock_dir = req.wdata[`C_XFER_DIR];
          nxt_st.sync_mode_select = req.wdata[`C_SYNC_MODE];
          nxt_st.parity_mode = req.wdata[`C_PARITY_HI:`C_PARITY_LO];
          nxt_st.stop_bits_select = req.wdata[`C_STOP_BITS];
          nxt_st.char_size[1:0] = req.wdata[`C_SIZE_HI:`C_SIZE_LO];
          nxt_st.sync_clock_polarity = req.wdata[`C_POLARITY];
        end
        `ADDR_DIV_LOW: nxt_st.div_low = req.wdata;
        `ADDR_DIV_HIGH: nxt_st.div_high = req.wdata[3:0];
        default: ;
      endcase
    end
    // a transmit-complete event in the clearing cycle still sets the flag
    if (tx_tick && nxt_st.tx_st == usart_pkg::TX_IDLE
        && st_ff.tx_st != usart_pkg::TX_IDLE) nxt_st.tx_done = 1'b1;

    // receive buffer, two entries; head is q0
    pop = req.rd && req.addr == `ADDR_DATA && st_ff.q_count != 2'h0;
    cnt_after_pop = {1'b0, st_ff.q_count} - {2'b00, pop};
    if (pop) begin
      nxt_st.q0 = st_ff.q1;
      nxt_st.overrun = 1'b0;
    end
    if (push) begin
      if (cnt_after_pop == 3'h0) begin
        nxt_st.q0 = new_entry;
      end else if (cnt_after_pop == 3'h1) begin
        nxt_st.q1 = new_entry;
      end else begin
        nxt_st.overrun = 1'b1;
      end
    end
    nxt_st.q_count = (push && cnt_after_pop != 3'h2) ? 2'(cnt_after_pop + 3'h1)
                                                     : cnt_after_pop[1:0];

    // read port, data one cycle after the strobe
    nxt_st.rd_data = 8'h00;
    if (req.rd) begin
      unique case (req.addr)
        `ADDR_DATA: nxt_st.rd_data = st_ff.q0.data[7:0];
        `ADDR_CTRL_A: begin
          nxt_st.rd_data[`A_RX_COMPLETE] = st_ff.q_count != 2'h0;
          nxt_st.rd_data[`A_TX_COMPLETE] = st_ff.tx_done;
          nxt_st.rd_data[`A_TX_EMPTY] = !st_ff.tx_full;
          nxt_st.rd_data[`A_FRAMING_ERR] = st_ff.q0.framing_error;
          nxt_st.rd_data[`A_OVERRUN] = st_ff.overrun;
          nxt_st.rd_data[`A_PARITY_ERR] = st_ff.q0.parity_err;
          nxt_st.rd_data[`A_DOUBLE_SPEED] = st_ff.double_speed;
        end
        `ADDR_CTRL_B: nxt_st.rd_data = {st_ff.ie[2], st_ff.ie[0], st_ff.ie[1],
                                        st_ff.rx_en, st_ff.tx_en, st_ff.char_size[2],
                                        st_ff.q0.data[8], st_ff.tx_ninth_bit};
        `ADDR_CTRL_C: nxt_st.rd_data = {st_ff.xfer_clock_dir, st_ff.sync_mode_select,
                                        st_ff.parity_mode, st_ff.stop_bits_select,
                                        st_ff.char_size[1:0], st_ff.sync_clock_polarity};
        `ADDR_DIV_LOW: nxt_st.rd_data = st_ff.div_low;
        `ADDR_DIV_HIGH: nxt_st.rd_data = {4'h0, st_ff.div_high};
        default: nxt_st.rd_data = 8'h00;
      endcase
    end

    // interrupt request levels
    nxt_st.irq.rx_done  = st_ff.ie[2] && nxt_st.q_count != 2'h0;
    nxt_st.irq.tx_empty = st_ff.ie[1] && !nxt_st.tx_full;
    nxt_st.irq.tx_done  = st_ff.ie[0] && nxt_st.tx_done;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.char_size <= `RST_SIZE;
      st_ff.baud_cnt <= `RST_DIV;
      st_ff.serial_out <= 1'b1;
      st_ff.rx_s1 <= 1'b1;
      st_ff.rx_s2 <= 1'b1;
      st_ff.tx_st <= usart_pkg::TX_IDLE;
      st_ff.rx_st <= usart_pkg::RX_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rd_data    = st_ff.rd_data;
  assign serial_out = st_ff.serial_out;
  assign xck        = st_ff.xck;
  assign irq        = st_ff.irq;

endmodule : usart_core

`default_nettype wire

// file: tb/usart_core_asserts.sv
`timescale 1ns/1ns
`default_nettype none
`include "usart_consts.svh"
module usart_core_asserts (
  input wire logic                clk,
  input wire logic                rst_n,
  input wire usart_pkg::bus_req_t req,
  input wire logic [7:0]          rd_data,
  input wire logic                serial_in,
  input wire logic                serial_out,
  input wire logic                xck_in,
  input wire usart_pkg::xck_pin_t xck,
  input wire usart_pkg::irq_t     irq
);
  // shadows of control bytes B and C and the divisor high byte, kept from bus writes so no peek inside is needed
  logic [7:0] c_ff;
  logic [7:0] b_ff;
  logic [3:0] dh_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      c_ff <= 8'h06;
      b_ff <= 8'h00;
      dh_ff <= 4'h0;
    end else if (req.wr) begin
      if (req.addr == `ADDR_CTRL_C) c_ff <= req.wdata;
      if (req.addr == `ADDR_CTRL_B) b_ff <= req.wdata;
      if (req.addr == `ADDR_DIV_HIGH) dh_ff <= req.wdata[3:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_rd_quiet: assert property (!req.rd |=> rd_data == 8'h00)
    else $error("read data not zero outside read slot");
  chk_unmapped_zero: assert property (req.rd && req.addr > `ADDR_DIV_HIGH |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  chk_ctrl_c_echo: assert property (
    req.rd && req.addr == `ADDR_CTRL_C |=> rd_data == $past(c_ff))
    else $error("frame format readback wrong");
  chk_div_high_echo: assert property (
    req.rd && req.addr == `ADDR_DIV_HIGH |=> rd_data[3:0] == $past(dh_ff))
    else $error("divisor high readback wrong");
  chk_oe_async_off: assert property (!c_ff[`C_SYNC_MODE] [*3] |-> !xck.oe)
    else $error("clock pin driven in async mode");
  chk_oe_master_on: assert property (
    (c_ff[`C_SYNC_MODE] && c_ff[`C_XFER_DIR]) [*3] |-> xck.oe)
    else $error("clock pin not driven in master mode");
  chk_irq_gate: assert property (
    (!b_ff[`B_IE_TX_EMPTY] && !b_ff[`B_IE_TX_DONE]) [*3] |-> !irq.tx_empty && !irq.tx_done)
    else $error("transmit event raised while disabled");
  chk_load_blocked: assert property (
    req.wr && req.addr == `ADDR_DATA && !b_ff[`B_TX_EN] && b_ff[`B_IE_TX_EMPTY]
    |-> ##2 !irq.tx_empty)
    else $error("buffer still empty after data write");
  cover property (req.wr && req.addr == `ADDR_DATA);
  cover property (xck.oe);
  cover property ($fell(serial_out));
  cover property (irq.rx_done && irq.tx_done);
endmodule : usart_core_asserts
`default_nettype wire

// file: tb/remote_uart.sv
`timescale 1ns/1ns
`default_nettype none
module remote_uart (
  input  wire logic clk,
  input  wire logic line_in,
  output var  logic line_out,
  output var  logic xck_out
);
  initial line_out = 1'b1;
  // stands still at the idle level outside frames
  initial xck_out = 1'b1;
  // bits leave lsb first, one period each; the line then idles high
  task automatic send(input logic [31:0] bits, input int n, input int blen);
    for (int i = 0; i < n; i++) begin
      line_out <= bits[i];
      repeat (blen) @(posedge clk);
    end
    line_out <= 1'b1;
  endtask : send
  // start is found on a low line, then each bit is taken near its middle
  task automatic grab(output logic [31:0] bits, input int n, input int blen, output bit ok);
    int t;
    bits = '1;
    ok = 1'b0;
    t = 0;
    while (line_in !== 1'b0 && t < 4000) begin
      @(posedge clk);
      t++;
    end
    if (t < 4000) begin
      ok = 1'b1;
      repeat (blen / 2) @(posedge clk);
      for (int i = 0; i < n; i++) begin
        bits[i] = line_in;
        repeat (blen) @(posedge clk);
      end
    end
  endtask : grab
  // slave-side clock for polarity 1: change on fall, sample on rise;
  // eight clk per period leaves one clk of margin after the three-clk clock sync delay
  task automatic xfer(input logic [31:0] tx_bits, output logic [31:0] rx_bits, input int n);
    rx_bits = '1;
    for (int i = 0; i < n; i++) begin
      xck_out  <= 1'b0;
      line_out <= tx_bits[i];
      repeat (4) @(posedge clk);
      xck_out  <= 1'b1;
      rx_bits[i] = line_in;
      repeat (4) @(posedge clk);
    end
    line_out <= 1'b1;
  endtask : xfer
endmodule : remote_uart
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "usart_consts.svh"
module tb_top;
  logic                clk;
  logic                rst_n;
  usart_pkg::bus_req_t req;
  logic [7:0]          rd_data;
  logic                serial_in;
  logic                serial_out;
  logic                xck_in;
  usart_pkg::xck_pin_t xck;
  usart_pkg::irq_t     irq;
  int                  fail_count;
  int                  cmp_count;
  usart_core DUT (.clk(clk), .rst_n(rst_n), .req(req), .rd_data(rd_data),
    .serial_in(serial_in), .serial_out(serial_out), .xck_in(xck_in), .xck(xck), .irq(irq));
  remote_uart peer (.clk(clk), .line_in(serial_out), .line_out(serial_in), .xck_out(xck_in));
  initial clk = 1'b0;
  always #2 clk = ~clk;
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rchk(input string what, input logic [2:0] a, input logic [7:0] m,
                      input logic [7:0] exp);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 check(what, {24'h0, rd_data & m}, {24'h0, exp});
  endtask : rchk
  // expected line image, start bit at index 0
  function automatic logic [31:0] frame(input logic [8:0] d, input int nb,
                                        input logic [1:0] pm, input int st);
    logic p;
    int   n;
    frame = '1;
    frame[0] = 1'b0;
    p = pm[0];
    for (int i = 0; i < nb; i++) begin
      frame[1 + i] = d[i];
      p ^= d[i];
    end
    n = 1 + nb;
    if (pm[1]) frame[n] = p;
  endfunction : frame
  task automatic expect_line(input string what, input int n, input int blen,
                             input logic [31:0] exp);
    logic [31:0] bits;
    bit          ok;
    peer.grab(bits, n, blen, ok);
    if (ok) begin
      check(what, bits, exp);
    end else begin
      fail_count++;
      report_and_stop();
    end
  endtask : expect_line
  task automatic t_reset();
    rchk("status", `ADDR_CTRL_A, 8'hff, 8'h20);
    rchk("ctrl_b", `ADDR_CTRL_B, 8'hff, 8'h00);
    rchk("format", `ADDR_CTRL_C, 8'hff, 8'h06);
    rchk("div_high", `ADDR_DIV_HIGH, 8'hff, 8'h00);
    rchk("unmapped", 3'h7, 8'hff, 8'h00);
    wr(`ADDR_CTRL_B, 8'h20);
    wr(`ADDR_DATA, 8'ha5);
    rchk("empty_after_write", `ADDR_CTRL_A, 8'h20, 8'h00);
    $display("reset test done");
  endtask : t_reset
  task automatic t_tx();
    wr(`ADDR_DIV_LOW, 8'h00);
    // the held byte leaves once the transmitter is switched on
    fork
      wr(`ADDR_CTRL_B, 8'h18);
      expect_line("frame_8n1", 10, 16, frame(9'h0a5, 8, 2'b00, 1));
    join
    $display("transmit test done");
  endtask : t_tx
  task automatic t_b2b();
    logic [31:0] exp;
    logic [31:0] f1;
    logic [31:0] f2;
    int          t;
    f1 = frame(9'h04b, 7, 2'b10, 2);
    f2 = frame(9'h01d, 7, 2'b10, 2);
    exp = '1;
    exp[21:0] = {f2[10:0], f1[10:0]};
    wr(`ADDR_CTRL_A, 8'h02);
    wr(`ADDR_CTRL_C, 8'h2c);
    fork
      begin
        wr(`ADDR_DATA, 8'h4b);
        t = 0;
        while (irq.tx_empty !== 1'b1 && t < 200) begin
          wr(`ADDR_CTRL_B, 8'h38);
          t++;
        end
        if (t < 200) begin
          wr(`ADDR_DATA, 8'h1d);
        end else begin
          fail_count++;
          report_and_stop();
        end
      end
      expect_line("two_frames_even", 22, 8, exp);
    join
    wr(`ADDR_CTRL_B, 8'h18);
    $display("back to back test done");
  endtask : t_b2b
  task automatic t_rx();
    logic [31:0] bad;
    wr(`ADDR_CTRL_A, 8'h00);
    wr(`ADDR_CTRL_C, 8'h36);
    bad = frame(9'h0c3, 8, 2'b11, 1);
    bad[10] = 1'b0;
    peer.send(frame(9'h03c, 8, 2'b11, 1), 11, 16);
    @(posedge clk);
    peer.send(bad, 11, 16);
    rchk("rx_head_flags", `ADDR_CTRL_A, 8'h94, 8'h80);
    rchk("rx_first", `ADDR_DATA, 8'hff, 8'h3c);
    rchk("rx_stop_low", `ADDR_CTRL_A, 8'h94, 8'h90);
    rchk("rx_second", `ADDR_DATA, 8'hff, 8'hc3);
    rchk("rx_drained", `ADDR_CTRL_A, 8'h80, 8'h00);
    $display("receive test done");
  endtask : t_rx
  task automatic t_master();
    wr(`ADDR_CTRL_C, 8'hc6);
    fork
      wr(`ADDR_DATA, 8'h5a);
      expect_line("master_frame", 10, 2, frame(9'h05a, 8, 2'b00, 1));
    join
    check("clock_out_enable", {31'h0, xck.oe}, 32'h1);
    wr(`ADDR_CTRL_C, 8'h06);
    repeat (3) @(posedge clk);
    check("clock_out_released", {31'h0, xck.oe}, 32'h0);
    $display("master test done");
  endtask : t_master
  task automatic t_slave();
    logic [31:0] got;
    wr(`ADDR_CTRL_C, 8'h47);
    wr(`ADDR_CTRL_A, 8'h40);
    // ninth bit goes in before the data byte that carries it
    wr(`ADDR_CTRL_B, 8'hdd);
    wr(`ADDR_DATA, 8'h96);
    check("slave_pin", {30'h0, xck.oe, xck.out}, 32'h1);
    rchk("tx_complete_clear", `ADDR_CTRL_A, 8'h40, 8'h00);
    peer.xfer(frame(9'h1e1, 9, 2'b00, 1), got, 12);
    check("slave_tx", got, frame(9'h196, 9, 2'b00, 1));
    check("irq_levels", {30'h0, irq.rx_done, irq.tx_done}, 32'h3);
    rchk("rx_ninth", `ADDR_CTRL_B, 8'h02, 8'h02);
    rchk("slave_rx", `ADDR_DATA, 8'hff, 8'he1);
    rchk("tx_complete_set", `ADDR_CTRL_A, 8'h40, 8'h40);
    $display("slave test done");
  endtask : t_slave
  initial begin
    req = '0;
    rst_n = 1'b0;
    fail_count = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_tx();
    t_b2b();
    t_rx();
    t_master();
    t_slave();
    report_and_stop();
  end
endmodule : tb_top
bind usart_core usart_core_asserts chk (.clk(clk), .rst_n(rst_n), .req(req),
  .rd_data(rd_data), .serial_in(serial_in), .serial_out(serial_out), .xck_in(xck_in),
  .xck(xck), .irq(irq));
`default_nettype wire
